/* core/ext_mem_pkg.sv */
package ext_mem_pkg;

  localparam int NUM_BANKS = 4;
  localparam int CFG_W = 16;

  // Address decode: 0x6000_0000 .. 0x67FF_FFFF holds the banks.
  localparam logic [4:0] EXT_SPACE_TOP = 5'h0C;
  localparam int BANK_SEL_LSB = 25;
  localparam int BANK_SEL_MSB = 26;
  localparam int BANK_HOLE_BIT = 24;
  localparam logic [1:0] BOOT_BANK = 2'h0;

  // Configuration window 0x6C00_0000 .. 0x6C00_000F, one word per bank.
  localparam logic [27:0] REG_WINDOW = 28'h6C00000;
  localparam logic [15:0] REG_ZERO_HI = 16'h0000;

  // Bank configuration fields.
  localparam int EN_BIT = 15;
  localparam int LEN_MSB = 5;
  localparam int LEN_LSB = 2;
  localparam int WID_MSB = 1;
  localparam int WID_LSB = 0;
  localparam logic [15:0] CFG_USED_MASK = 16'h803F;
  localparam logic [63:0] CFG_RESET_ALL = 64'h003C_003E_003D_803D;
  localparam logic [1:0] WIDTH_8BIT = 2'h0;

  // Internal access sizes.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Chip select lasts the cycle length field plus this many clocks.
  localparam logic [4:0] CS_EXTRA = 5'h02;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } state_t;

endpackage : ext_mem_pkg

/* core/bank_config_file.sv */
`timescale 1ns/1ps
`default_nettype none

module bank_config_file (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  output logic [63:0] cfg_flat
);

  // One configuration word per bank; reserved bits are never stored.
  // Each bank keeps its own register so no variable has two writers.
  for (genvar b = 0; b < ext_mem_pkg::NUM_BANKS; b++)
  begin : g_bank
    logic [15:0] word_r;
    logic [15:0] word_nxt;

    always_comb
    begin
      if (wr_en && wr_idx == 2'(b))
        word_nxt = wr_data & ext_mem_pkg::CFG_USED_MASK;
      else
        word_nxt = word_r;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        word_r <= ext_mem_pkg::CFG_RESET_ALL[b*16 +: 16];
      else
        word_r <= word_nxt;
    end

    assign cfg_flat[b*16 +: 16] = word_r;
  end

endmodule : bank_config_file

`default_nettype wire

/* core/ext_mem_iface.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R01] Four banks selected by address bits 26:25.
// [R02] Only the addressed bank's select goes low.
// [R03] Drive 24 address lines, 16-bit data bus.
// [R04] Read strobe low during reads only.
// [R05] Two byte write strobes, low and high lane.
// [R06] Banks at 0x6000_0000 plus 32 MB steps.
// [R07] Config window 0x6C00_0000, 16-bit access only.
// [R08] Bank 0 always 16 bits wide.
// [R09] Zero to fifteen wait states per bank.
// [R10] Single write: select lasts length plus two.
// [R11] Single read: select lasts length plus two.
// [R12] N sub-cycles: select lasts N times single.
// [R13] Select held; write strobe gaps between subwrites.
// [R14] 8-bit bank uses low lane only.
// [R15] Word to 8-bit bank: addresses 00 to 11.
// [R16] Half write, 16-bit bank: both strobes, A0 kept.
// [R17] Word read, 16-bit bank: two reads assembled.
// [R18] Word read halves at addresses 00 then 10.
// [R19] No clock means the access never completes.
// [R20] Each bank has an accessible flag.
// [R21] Width code 00 is 8-bit, else 16-bit.
// [R22] Bit 15 enables the bank.
// [R23] Byte write to 16-bit bank: one lane strobe.
module ext_mem_iface (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  output logic busy,
  output logic ack,
  output logic err,
  output logic [31:0] rdata,
  output logic [3:0] bank_select_n,
  output logic [23:0] mem_addr,
  input wire logic [15:0] mem_data_in,
  output logic [15:0] mem_data_out,
  output logic mem_data_oe,
  output logic read_strobe_n,
  output logic [1:0] write_strobe_n
);

  ext_mem_pkg::state_t state_r, state_nxt;
  logic [1:0] bank_r, bank_nxt;
  logic wr_r, wr_nxt;
  logic [1:0] size_r, size_nxt;
  logic wide_r, wide_nxt;
  logic [4:0] len_r, len_nxt;
  logic [2:0] nsub_r, nsub_nxt;
  logic [1:0] sub_r, sub_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  logic [23:0] base_r, base_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] rbuf_r, rbuf_nxt;
  logic [3:0] cs_n_r, cs_n_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  logic rd_n_r, rd_n_nxt;
  logic [1:0] we_n_r, we_n_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic busy_r, busy_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [63:0] cfg_flat;
  logic cfg_we;
  logic [15:0] req_cfg;
  logic [15:0] bank_cfg;
  logic ext_hit;
  logic reg_hit;
  logic last_sub;

  ////////////////////////////////////////////////////////////////////////////

  bank_config_file u_cfg (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(cfg_we),
    .wr_idx(req_addr[3:2]),
    .wr_data(req_wdata[15:0]),
    .cfg_flat(cfg_flat)
  );

  assign req_cfg = cfg_flat[{req_addr[3:2], 4'h0} +: 16];
  assign bank_cfg = cfg_flat[{req_addr[26:25], 4'h0} +: 16]; // [R01]
  assign ext_hit = req_addr[31:27] == ext_mem_pkg::EXT_SPACE_TOP &&
                   !req_addr[ext_mem_pkg::BANK_HOLE_BIT]; // [R06]
  assign reg_hit = req_addr[31:4] == ext_mem_pkg::REG_WINDOW; // [R07]
  assign last_sub = {1'b0, sub_r} == nsub_r - 3'h1;

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic wide_v;
    logic last_v;
    logic gap_v;
    logic [1:0] lo_v;
    logic [31:0] rb_v;
    wide_v = 1'b0;
    last_v = 1'b0;
    gap_v = 1'b0;
    lo_v = 2'h0;
    rb_v = rbuf_r;
    state_nxt = state_r;
    bank_nxt = bank_r;
    wr_nxt = wr_r;
    size_nxt = size_r;
    wide_nxt = wide_r;
    len_nxt = len_r;
    nsub_nxt = nsub_r;
    sub_nxt = sub_r;
    cyc_nxt = cyc_r;
    base_nxt = base_r;
    wdata_nxt = wdata_r;
    rbuf_nxt = rbuf_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    cfg_we = 1'b0;
    case (state_r)
      ext_mem_pkg::ST_IDLE:
      begin
        if (req && reg_hit)
        begin
          ack_nxt = 1'b1;
          if (req_size != ext_mem_pkg::SIZE_HALF || req_addr[1:0] != 2'h0)
            err_nxt = 1'b1; // [R07]
          else if (req_write)
            cfg_we = 1'b1;
          else
            rdata_nxt = {ext_mem_pkg::REG_ZERO_HI, req_cfg};
        end
        else if (req && ext_hit && !bank_cfg[ext_mem_pkg::EN_BIT])
        begin
          ack_nxt = 1'b1; // [R20] [R22]
          err_nxt = 1'b1;
        end
        else if (req && ext_hit)
        begin
          // Bank 0 ignores its width field so boot memory stays 16 bits.
          wide_v = bank_cfg[ext_mem_pkg::WID_MSB:ext_mem_pkg::WID_LSB] !=
                   ext_mem_pkg::WIDTH_8BIT ||
                   req_addr[26:25] == ext_mem_pkg::BOOT_BANK; // [R08] [R21]
          state_nxt = ext_mem_pkg::ST_XFER;
          bank_nxt = req_addr[ext_mem_pkg::BANK_SEL_MSB:
                              ext_mem_pkg::BANK_SEL_LSB]; // [R01]
          wr_nxt = req_write;
          size_nxt = req_size;
          wide_nxt = wide_v;
          len_nxt = 5'(bank_cfg[ext_mem_pkg::LEN_MSB:ext_mem_pkg::LEN_LSB]) +
                    ext_mem_pkg::CS_EXTRA; // [R09] [R10] [R11]
          case (req_size)
            ext_mem_pkg::SIZE_WORD: nsub_nxt = wide_v ? 3'h2 : 3'h4; // [R12]
            ext_mem_pkg::SIZE_HALF: nsub_nxt = wide_v ? 3'h1 : 3'h2;
            default: nsub_nxt = 3'h1;
          endcase
          if (req_size == ext_mem_pkg::SIZE_WORD)
            base_nxt = {req_addr[23:2], 2'h0}; // [R15] [R18]
          else if (req_size == ext_mem_pkg::SIZE_HALF && !wide_v)
            base_nxt = {req_addr[23:1], 1'b0};
          else
            base_nxt = req_addr[23:0]; // [R16]
          sub_nxt = 2'h0;
          cyc_nxt = 5'h00;
          wdata_nxt = req_wdata;
          rbuf_nxt = 32'h0000_0000;
        end
        else if (req)
        begin
          ack_nxt = 1'b1;
          err_nxt = 1'b1;
        end
      end
      ext_mem_pkg::ST_XFER:
      begin
        // Without a clock this state is never left, so the access hangs.
        // [R19]
        cyc_nxt = cyc_r + 5'h01;
        if (cyc_r == len_r - 5'h01)
        begin
          cyc_nxt = 5'h00;
          if (!wide_r)
            rb_v[{sub_r, 3'h0} +: 8] = mem_data_in[7:0];
          else if (size_r == ext_mem_pkg::SIZE_WORD)
            rb_v[{sub_r[0], 4'h0} +: 16] = mem_data_in; // [R17]
          else if (size_r == ext_mem_pkg::SIZE_HALF)
            rb_v[15:0] = mem_data_in;
          else
            rb_v[7:0] = base_r[0] ? mem_data_in[15:8] : mem_data_in[7:0];
          if (!wr_r)
            rbuf_nxt = rb_v;
          if (last_sub)
          begin
            state_nxt = ext_mem_pkg::ST_IDLE;
            ack_nxt = 1'b1;
            if (!wr_r)
              rdata_nxt = rb_v; // [R17]
          end
          else
            sub_nxt = sub_r + 2'h1;
        end
      end
      default:
      begin
        state_nxt = ext_mem_pkg::ST_IDLE;
      end
    endcase

    // Pin values follow the state being entered, so they line up with it.
    last_v = {1'b0, sub_nxt} == nsub_nxt - 3'h1;
    if (wide_nxt)
      lo_v = {base_nxt[1] | sub_nxt[0], base_nxt[0]}; // [R16] [R18]
    else
      lo_v = base_nxt[1:0] + sub_nxt; // [R15]
    busy_nxt = state_nxt == ext_mem_pkg::ST_XFER;
    cs_n_nxt = 4'hF;
    if (busy_nxt)
      cs_n_nxt[bank_nxt] = 1'b0; // [R02] [R13]
    addr_nxt = {base_nxt[23:2], lo_v}; // [R03]
    rd_n_nxt = !(busy_nxt && !wr_nxt); // [R04]
    gap_v = cyc_nxt == len_nxt - 5'h01 && !last_v; // [R13]
    we_n_nxt = 2'h3;
    if (busy_nxt && wr_nxt && !gap_v)
    begin
      if (!wide_nxt)
        we_n_nxt = 2'h2; // [R14]
      else if (size_nxt == ext_mem_pkg::SIZE_BYTE)
        we_n_nxt = base_nxt[0] ? 2'h1 : 2'h2; // [R23]
      else
        we_n_nxt = 2'h0; // [R05] [R16]
    end
    if (!wide_nxt)
      dout_nxt = {8'h00, wdata_nxt[{sub_nxt, 3'h0} +: 8]}; // [R14]
    else if (size_nxt == ext_mem_pkg::SIZE_WORD)
      dout_nxt = wdata_nxt[{sub_nxt[0], 4'h0} +: 16];
    else if (size_nxt == ext_mem_pkg::SIZE_BYTE)
      dout_nxt = {wdata_nxt[7:0], wdata_nxt[7:0]};
    else
      dout_nxt = wdata_nxt[15:0];
    doe_nxt = busy_nxt && wr_nxt; // [R03]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ext_mem_pkg::ST_IDLE;
      bank_r <= 2'h0;
      wr_r <= 1'b0;
      size_r <= 2'h0;
      wide_r <= 1'b0;
      len_r <= 5'h00;
      nsub_r <= 3'h0;
      sub_r <= 2'h0;
      cyc_r <= 5'h00;
      base_r <= 24'h000000;
      wdata_r <= 32'h0000_0000;
      rbuf_r <= 32'h0000_0000;
      cs_n_r <= 4'hF;
      addr_r <= 24'h000000;
      dout_r <= 16'h0000;
      doe_r <= 1'b0;
      rd_n_r <= 1'b1;
      we_n_r <= 2'h3;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      busy_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      bank_r <= bank_nxt;
      wr_r <= wr_nxt;
      size_r <= size_nxt;
      wide_r <= wide_nxt;
      len_r <= len_nxt;
      nsub_r <= nsub_nxt;
      sub_r <= sub_nxt;
      cyc_r <= cyc_nxt;
      base_r <= base_nxt;
      wdata_r <= wdata_nxt;
      rbuf_r <= rbuf_nxt;
      cs_n_r <= cs_n_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rd_n_r <= rd_n_nxt;
      we_n_r <= we_n_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      busy_r <= busy_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign busy = busy_r;
  assign ack = ack_r;
  assign err = err_r;
  assign rdata = rdata_r;
  assign bank_select_n = cs_n_r;
  assign mem_addr = addr_r;
  assign mem_data_out = dout_r;
  assign mem_data_oe = doe_r;
  assign read_strobe_n = rd_n_r;
  assign write_strobe_n = we_n_r;

  ////////////////////////////////////////////////////////////////////////////

  // Counts how long a bank select has been low, for the length check.
  logic [7:0] cs_cnt_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cs_cnt_r <= 8'h00;
    else if (!(&cs_n_r))
      cs_cnt_r <= cs_cnt_r + 8'h01;
    else
      cs_cnt_r <= 8'h00;
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence wr_gap_s;
    (&write_strobe_n) && !(&bank_select_n);
  endsequence

  sequence wr_resume_s;
    !(&write_strobe_n) && !(&bank_select_n);
  endsequence

  cs_one_hot_a: assert property ($countones(~bank_select_n) <= 1) // [R02]
    else $error("More than one bank select is active.");

  read_excl_a: assert property (!read_strobe_n |-> // [R04]
    (&write_strobe_n) && !mem_data_oe)
    else $error("Read strobe overlaps a write.");

  cs_length_a: assert property ($rose(&bank_select_n) |-> // [R12]
    cs_cnt_r == len_r * nsub_r)
    else $error("Bank select length is wrong.");

  strobe_gap_a: assert property (busy_r && wr_r && // [R13]
    cyc_r == len_r - 5'h01 && !last_sub |-> wr_gap_s ##1 wr_resume_s)
    else $error("Write strobe gap between sub-writes is wrong.");

  narrow_lane_a: assert property (busy_r && wr_r && !wide_r |-> // [R14]
    write_strobe_n[1])
    else $error("High lane strobed on an 8-bit bank.");

  narrow_addr_a: assert property (busy_r && !wide_r && // [R15]
    size_r == ext_mem_pkg::SIZE_WORD |-> mem_addr[1:0] == sub_r)
    else $error("Byte address step on an 8-bit bank is wrong.");

  half_write_a: assert property (busy_r && wr_r && wide_r && // [R16]
    size_r == ext_mem_pkg::SIZE_HALF |->
    write_strobe_n == 2'h0 && mem_addr[0] == base_r[0])
    else $error("Half-word write strobes or address are wrong.");

  word_read_addr_a: assert property (busy_r && !wr_r && wide_r && // [R18]
    size_r == ext_mem_pkg::SIZE_WORD |-> mem_addr[1:0] == {sub_r[0], 1'b0})
    else $error("Word read half address is wrong.");

  word_read_data_a: assert property (ack_r && $past(busy_r) && // [R17]
    !wr_r && wide_r && size_r == ext_mem_pkg::SIZE_WORD |->
    rdata_r[31:16] == $past(mem_data_in))
    else $error("Word read upper half is not the second read.");

  bank_off_a: assert property (state_r == ext_mem_pkg::ST_IDLE && req && // [R22]
    ext_hit && !bank_cfg[ext_mem_pkg::EN_BIT] |=> (&bank_select_n) && err)
    else $error("Disabled bank was accessed.");

  boot_wide_a: assert property (busy_r && bank_r == 2'h0 |-> wide_r) // [R08]
    else $error("Boot bank is not 16 bits wide.");

  access_done_a: assert property ($rose(busy_r) |-> ##[2:68] ack_r) // [R11]
    else $error("External access did not finish in time.");

endmodule : ext_mem_iface

`default_nettype wire

/* tb/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Memory parts on all four banks; bank 1 holds a byte-wide part.
module ext_mem_model #(
  parameter logic [3:0] WIDE_MASK = 4'hD
) (
  input wire logic clk,
  input wire logic [3:0] bank_select_n,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_data_out,
  input wire logic read_strobe_n,
  input wire logic [1:0] write_strobe_n,
  output logic [15:0] mem_data_in
);
  logic [7:0] mem [4][256];
  logic [15:0] last_q = 16'h0000;
  logic [1:0] bank;
  logic wide;
  logic [7:0] lo_a;

  always_comb
  begin
    bank = 2'h0;
    for (int i = 0; i < 4; i++)
      if (!bank_select_n[i])
        bank = i[1:0];
    wide = WIDE_MASK[bank];
    lo_a = wide ? {mem_addr[7:1], 1'b0} : mem_addr[7:0];
  end

  // A released bus shows the inverse of its last value, never a stale copy.
  assign mem_data_in = (&bank_select_n || read_strobe_n) ? ~last_q :
    {wide ? mem[bank][lo_a | 8'h01] : ~mem[bank][lo_a], mem[bank][lo_a]};

  always @(posedge clk)
  begin
    last_q <= mem_data_in;
    if (!(&bank_select_n) && !write_strobe_n[0])
      mem[bank][lo_a] <= mem_data_out[7:0];
    if (!(&bank_select_n) && !write_strobe_n[1] && wide)
      mem[bank][lo_a | 8'h01] <= mem_data_out[15:8];
  end
endmodule : ext_mem_model

`default_nettype wire

/* tb/ext_mem_iface_test.sv */
`timescale 1ns/1ps
`default_nettype none

module ext_mem_iface_test;
  localparam logic [1:0] BYTE = ext_mem_pkg::SIZE_BYTE;
  localparam logic [1:0] HALF = ext_mem_pkg::SIZE_HALF;
  localparam logic [1:0] WORD = ext_mem_pkg::SIZE_WORD;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req = 1'b0;
  logic [31:0] req_addr = 32'h00000000;
  logic req_write = 1'b0;
  logic [1:0] req_size = 2'h0;
  logic [31:0] req_wdata = 32'h00000000;
  logic busy, ack, err, mem_data_oe, read_strobe_n;
  logic [31:0] rdata;
  logic [3:0] bank_select_n, sel_seen, addr_seen;
  logic [23:0] mem_addr;
  logic [15:0] mem_data_in, mem_data_out;
  logic [1:0] write_strobe_n, lanes;
  int num_errors = 0;
  int comparisons = 0;
  int we_cycles;

  always #50 clk = ~clk;

  ext_mem_iface dut (.clk(clk), .reset_n(reset_n), .req(req),
    .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .req_wdata(req_wdata), .busy(busy), .ack(ack), .err(err), .rdata(rdata),
    .bank_select_n(bank_select_n), .mem_addr(mem_addr),
    .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n));

  ext_mem_model model (.clk(clk), .bank_select_n(bank_select_n),
    .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .mem_data_in(mem_data_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check_flag

  // Starts at a falling edge and returns at the falling edge showing ack.
  task automatic access(input logic wr, input logic [1:0] size,
    input logic [31:0] addr, input logic [31:0] wd, input int exp_cs,
    input logic exp_err);
    int n, cs, rd;
    n = 0;
    cs = 0;
    rd = 0;
    we_cycles = 0;
    lanes = 2'h0;
    addr_seen = 4'h0;
    sel_seen = 4'hF;
    req = 1'b1;
    req_write = wr;
    req_size = size;
    req_addr = addr;
    req_wdata = wd;
    do
    begin
      @(negedge clk);
      req = 1'b0;
      n++;
      if (!(&bank_select_n))
      begin
        cs++;
        addr_seen[mem_addr[1:0]] = 1'b1;
        sel_seen = sel_seen & bank_select_n;
      end
      if (!read_strobe_n)
        rd++;
      if (write_strobe_n != 2'h3)
        we_cycles++;
      lanes = lanes | ~write_strobe_n;
    end while (ack !== 1'b1 && n < 100);
    check_flag(ack, 1'b1);
    check_flag(err, exp_err);
    check_word(32'(cs), 32'(exp_cs));
    check_word(32'(rd), wr ? 32'h0 : 32'(exp_cs));
  endtask : access

  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check_word({28'h0, bank_select_n}, 32'h0000000F);
    check_flag(read_strobe_n, 1'b1);
    check_word({30'h0, write_strobe_n}, 32'h00000003);
    check_flag(busy, 1'b0);
    access(1'b0, HALF, 32'h6C00000C, 32'h0, 0, 1'b0);
    check_word(rdata, 32'h0000003C);
    access(1'b0, HALF, 32'h6C000000, 32'h0, 0, 1'b0);
    check_word(rdata, 32'h0000803D);
    $display("test reset done");
  endtask : test_reset

  task automatic test_config;
    access(1'b1, HALF, 32'h6C000004, 32'h0000FFC0, 0, 1'b0);
    access(1'b0, HALF, 32'h6C000004, 32'h0, 0, 1'b0);
    check_word(rdata, 32'h00008000);
    access(1'b1, HALF, 32'h6C000000, 32'h00008004, 0, 1'b0);
    access(1'b1, BYTE, 32'h6C000000, 32'h00000000, 0, 1'b1);
    access(1'b1, HALF, 32'h6C000002, 32'h00000000, 0, 1'b1);
    access(1'b0, HALF, 32'h6C000000, 32'h0, 0, 1'b0);
    check_word(rdata, 32'h00008004);
    $display("test config done");
  endtask : test_config

  task automatic test_byte_bank;
    access(1'b1, WORD, 32'h62000010, 32'hA16F2DDA, 8, 1'b0);
    check_word(32'(we_cycles), 32'h5);
    check_word({30'h0, lanes}, 32'h1);
    check_word({28'h0, addr_seen}, 32'hF);
    check_word({28'h0, sel_seen}, 32'hD);
    access(1'b0, WORD, 32'h62000010, 32'h0, 8, 1'b0);
    check_word(rdata, 32'hA16F2DDA);
    $display("test byte bank done");
  endtask : test_byte_bank

  task automatic test_wide_bank;
    access(1'b1, HALF, 32'h60000002, 32'h00001234, 3, 1'b0);
    check_word({30'h0, lanes}, 32'h3);
    check_word({28'h0, addr_seen}, 32'h4);
    check_word({28'h0, sel_seen}, 32'hE);
    access(1'b1, BYTE, 32'h60000005, 32'h0000005A, 3, 1'b0);
    check_word({30'h0, lanes}, 32'h2);
    access(1'b1, WORD, 32'h60000008, 32'hCAFEBEEF, 6, 1'b0);
    access(1'b0, WORD, 32'h60000008, 32'h0, 6, 1'b0);
    check_word(rdata, 32'hCAFEBEEF);
    check_word({28'h0, addr_seen}, 32'h5);
    access(1'b0, HALF, 32'h60000002, 32'h0, 3, 1'b0);
    check_word(rdata, 32'h00001234);
    access(1'b0, BYTE, 32'h60000005, 32'h0, 3, 1'b0);
    check_word(rdata, 32'h0000005A);
    $display("test wide bank done");
  endtask : test_wide_bank

  task automatic test_errors;
    access(1'b0, HALF, 32'h64000000, 32'h0, 0, 1'b1);
    access(1'b1, HALF, 32'h61000000, 32'h0, 0, 1'b1);
    access(1'b0, HALF, 32'h68000000, 32'h0, 0, 1'b1);
    access(1'b0, HALF, 32'h70000000, 32'h0, 0, 1'b1);
    $display("test errors done");
  endtask : test_errors

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    test_reset;
    test_config;
    test_byte_bank;
    test_wide_bank;
    test_errors;
    end_of_test;
  end

  // The whole run needs under a hundred cycles; allow ample margin.
  initial
  begin
    #(100 * 5000);
    num_errors++;
    end_of_test;
  end
endmodule : ext_mem_iface_test

`default_nettype wire
